/* logic/pwg_defines.svh */
// Register offsets, field positions, reset values and widths of the PWM generator
`ifndef PWG_DEFINES_SVH
`define PWG_DEFINES_SVH

// ==========================================================================
// Register offsets (byte addresses)
`define PWG_OFF_CTL      8'h00
`define PWG_OFF_SYNC     8'h04
`define PWG_OFF_ENABLE   8'h08
`define PWG_OFF_INVERT   8'h0C
`define PWG_OFF_FAULT    8'h10
`define PWG_OFF_INTEN    8'h14
`define PWG_OFF_RIS      8'h18
`define PWG_OFF_ISC      8'h1C
`define PWG_OFF_STATUS   8'h20
`define PWG_OFF_GCTL     8'h40
`define PWG_OFF_GINTEN   8'h44
`define PWG_OFF_GRIS     8'h48
`define PWG_OFF_GISC     8'h4C
`define PWG_OFF_LOAD     8'h50
`define PWG_OFF_COUNT    8'h54
`define PWG_OFF_CMPA     8'h58
`define PWG_OFF_CMPB     8'h5C
`define PWG_OFF_GENA     8'h60
`define PWG_OFF_GENB     8'h64
`define PWG_OFF_DBCTL    8'h68
`define PWG_OFF_DBRISE   8'h6C
`define PWG_OFF_DBFALL   8'h70

// ==========================================================================
// Field positions
`define PWG_GCTL_EN      0
`define PWG_GCTL_UPDOWN  1
`define PWG_GCTL_DBGSTOP 2
`define PWG_GCTL_SYNCUPD 3
`define PWG_INTEN_FAULT  16
`define PWG_GINTEN_TRG   8
`define PWG_STATUS_DIR   1

// ==========================================================================
// Widths and reset values
`define PWG_CNT_W        16
`define PWG_DB_W         12
`define PWG_ACT_W        12
`define PWG_NUM_EV       6
`define PWG_RST_CNT      16'h0000
`define PWG_RST_DB       12'h000

`endif

/* logic/pwg_edge_delay.sv */
// Rising-edge delay stage of the dead-band generator
`include "pwg_defines.svh"

module pwg_edge_delay (
  input  wire logic                   i_clk,
  input  wire logic                   i_arst_n,
  input  wire logic                   i_level,
  input  wire logic [`PWG_DB_W-1:0]   i_delay,
  output logic                        o_level
);

  logic [`PWG_DB_W-1:0] cnt_q;

  // Falls at once, rises only after the input has stayed high for i_delay cycles
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_q   <= `PWG_RST_DB;
      o_level <= 1'b0;
    end else if (!i_level) begin
      cnt_q   <= `PWG_RST_DB;
      o_level <= 1'b0;
    end else if (cnt_q >= i_delay) begin
      o_level <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 12'h001;
    end
  end

endmodule : pwg_edge_delay

/* logic/pwg_pkg.sv */
// Types shared by the PWM generator modules
package pwg_pkg;

  // ==========================================================================
  // Action taken by an output on one event
  typedef enum logic [1:0] {
    PWG_ACT_NONE   = 2'h0,
    PWG_ACT_INVERT = 2'h1,
    PWG_ACT_LOW    = 2'h2,
    PWG_ACT_HIGH   = 2'h3
  } pwg_act_t;

  // Position of each counter event in the event vector
  typedef enum int {
    PWG_EV_ZERO  = 0,
    PWG_EV_LOAD  = 1,
    PWG_EV_AUP   = 2,
    PWG_EV_ADOWN = 3,
    PWG_EV_BUP   = 4,
    PWG_EV_BDOWN = 5
  } pwg_ev_t;

endpackage : pwg_pkg

/* logic/pwg_top.sv */
// PWM generator with counter, compare events, action generator, dead-band and output control
// Behaviour
// - Down mode counts load to zero, reloads
// - Up/down mode counts zero to load, back
// - Direction low in down mode, toggles otherwise
// - One-cycle zero and load pulses
// - Compare match pulses split by direction
// - Compare above load never matches
// - Four events down mode, six up/down
// - Compare events dropped on zero/load
// - Coinciding A/B: each output uses own
// - Per-event action: none, invert, low, high
// - Dead-band disabled passes both outputs
// - Dead-band first output delays rising edge
// - Second output inverted, delayed, never overlapping
// - Interrupt on any selected event
// - ADC trigger on independent selected set
// - Interrupt/trigger use undelayed raw events
// - Global sync clears counter to zero
// - Immediate updates apply at counter zero
// - Synchronous updates wait for update request
// - Per-output fault enable forces inactive
// - Debug stall: continue, or halt at zero
// - Output enable mask, then inversion
// - Counter is sixteen bits wide
// - Disabled channel feeds zero to inverter
// - Update request self-clears, software cannot clear
//
// Implementation choices: the placing of the registers and the address-and-strobe port.
`include "pwg_defines.svh"

module pwg_top
  import pwg_pkg::*;
(
  input  wire logic        I_CORE_CLK,
  input  wire logic        I_ARST_N,
  input  wire logic [7:0]  I_ADDR,
  input  wire logic [31:0] I_WDATA,
  input  wire logic        I_WR,
  input  wire logic        I_RD,
  input  wire logic        I_FAULT,
  input  wire logic        I_DBG_STALL,
  output logic      [31:0] O_RDATA,
  output logic      [1:0]  O_PWM,
  output logic             O_INT,
  output logic             O_ADC_TRIG
);

  // ==========================================================================
  // Registers
  logic                   upd_req_q;
  logic                   gen_en_q, updown_q, dbg_stop_q, sync_mode_q;
  logic [1:0]             out_en_q, inv_q, flt_en_q;
  logic                   flt_int_en_q, flt_ris_q;
  logic [5:0]             int_sel_q, trg_sel_q, ris_q;
  logic [`PWG_CNT_W-1:0]  load_sh_q, cmpa_sh_q, cmpb_sh_q;
  logic [`PWG_CNT_W-1:0]  load_q, cmpa_q, cmpb_q, cnt_q;
  logic                   dir_q;
  logic [`PWG_ACT_W-1:0]  gena_q, genb_q;
  logic                   db_en_q;
  logic [`PWG_DB_W-1:0]   db_rise_q, db_fall_q;
  logic                   gen_a_q, gen_b_q;
  logic                   db_a, db_b;

  logic                   sync_wr, req_wr, run, at_zero, at_load, apply;
  logic                   mat_a, mat_b;
  logic [`PWG_CNT_W-1:0]  load_eff;
  logic [5:0]             ev, evg_a, evg_b;
  logic                   ga_d, gb_d;
  logic [1:0]             pre;
  logic [31:0]            rd_val;

  assign sync_wr = I_WR && (I_ADDR == `PWG_OFF_SYNC) && I_WDATA[0];
  assign req_wr  = I_WR && (I_ADDR == `PWG_OFF_CTL) && I_WDATA[0];

  // ==========================================================================
  // Counter and events
  assign at_zero  = (cnt_q == `PWG_RST_CNT);
  assign at_load  = (cnt_q == load_q);
  // Halt only once zero is reached, so a stall never cuts a period short
  assign run      = gen_en_q && !(I_DBG_STALL && dbg_stop_q && at_zero);
  assign apply    = at_zero && (!sync_mode_q || upd_req_q);
  assign load_eff = apply ? load_sh_q : load_q;
  assign mat_a    = run && (cnt_q == cmpa_q) && (cmpa_q <= load_q);
  assign mat_b    = run && (cnt_q == cmpb_q) && (cmpb_q <= load_q);

  always_comb begin
    ev               = 6'h00;
    ev[PWG_EV_ZERO]  = run && at_zero;
    ev[PWG_EV_LOAD]  = run && at_load;
    ev[PWG_EV_AUP]   = mat_a && dir_q;
    ev[PWG_EV_ADOWN] = mat_a && !dir_q;
    ev[PWG_EV_BUP]   = mat_b && dir_q;
    ev[PWG_EV_BDOWN] = mat_b && !dir_q;
  end

  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      cnt_q <= `PWG_RST_CNT;
      dir_q <= 1'b0;
    end else if (sync_wr) begin
      cnt_q <= `PWG_RST_CNT;
      dir_q <= updown_q;
    end else if (run) begin
      if (!updown_q) begin
        dir_q <= 1'b0;
        cnt_q <= at_zero ? load_eff : cnt_q - 16'h0001;
      end else if (dir_q) begin
        if (cnt_q >= load_q) begin
          dir_q <= 1'b0;
          cnt_q <= at_zero ? `PWG_RST_CNT : cnt_q - 16'h0001;
        end else begin
          cnt_q <= cnt_q + 16'h0001;
        end
      end else if (at_zero) begin
        dir_q <= 1'b1;
        cnt_q <= (load_eff == `PWG_RST_CNT) ? `PWG_RST_CNT : 16'h0001;
      end else begin
        cnt_q <= cnt_q - 16'h0001;
      end
    end
  end

  // ==========================================================================
  // Shadow and active period/compare values
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      load_sh_q <= `PWG_RST_CNT;
      cmpa_sh_q <= `PWG_RST_CNT;
      cmpb_sh_q <= `PWG_RST_CNT;
      load_q    <= `PWG_RST_CNT;
      cmpa_q    <= `PWG_RST_CNT;
      cmpb_q    <= `PWG_RST_CNT;
    end else begin
      if (I_WR && I_ADDR == `PWG_OFF_LOAD) load_sh_q <= I_WDATA[15:0];
      if (I_WR && I_ADDR == `PWG_OFF_CMPA) cmpa_sh_q <= I_WDATA[15:0];
      if (I_WR && I_ADDR == `PWG_OFF_CMPB) cmpb_sh_q <= I_WDATA[15:0];
      if (apply) begin
        load_q <= load_sh_q;
        cmpa_q <= cmpa_sh_q;
        cmpb_q <= cmpb_sh_q;
      end
    end
  end

  // Set by software, cleared only by the applied update; a new set wins
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      upd_req_q <= 1'b0;
    end else if (req_wr) begin
      upd_req_q <= 1'b1;
    end else if (apply && upd_req_q) begin
      upd_req_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Signal generator
  function automatic logic act_apply(input logic cur, input logic [1:0] act);
    unique case (pwg_act_t'(act))
      PWG_ACT_NONE:   act_apply = cur;
      PWG_ACT_INVERT: act_apply = !cur;
      PWG_ACT_LOW:    act_apply = 1'b0;
      PWG_ACT_HIGH:   act_apply = 1'b1;
    endcase
  endfunction : act_apply

  always_comb begin
    evg_a = ev;
    evg_b = ev;
    if (ev[PWG_EV_ZERO] || ev[PWG_EV_LOAD]) begin
      evg_a[5:2] = 4'h0;
      evg_b[5:2] = 4'h0;
    end
    if (|evg_a[3:2] && |evg_a[5:4]) begin
      evg_a[5:4] = 2'h0;
      evg_b[3:2] = 2'h0;
    end
    ga_d = gen_a_q;
    gb_d = gen_b_q;
    for (int i = 0; i < `PWG_NUM_EV; i++) begin
      if (evg_a[i]) ga_d = act_apply(ga_d, gena_q[2*i +: 2]);
      if (evg_b[i]) gb_d = act_apply(gb_d, genb_q[2*i +: 2]);
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      gen_a_q <= 1'b0;
      gen_b_q <= 1'b0;
    end else begin
      gen_a_q <= ga_d;
      gen_b_q <= gb_d;
    end
  end

  // ==========================================================================
  // Dead-band and output control
  pwg_edge_delay u_rise (
    .i_clk    (I_CORE_CLK),
    .i_arst_n (I_ARST_N),
    .i_level  (gen_a_q),
    .i_delay  (db_rise_q),
    .o_level  (db_a)
  );

  pwg_edge_delay u_fall (
    .i_clk    (I_CORE_CLK),
    .i_arst_n (I_ARST_N),
    .i_level  (!gen_a_q),
    .i_delay  (db_fall_q),
    .o_level  (db_b)
  );

  // Bypass is one cycle shorter than the delayed path
  assign pre = db_en_q ? {db_b, db_a} : {gen_b_q, gen_a_q};

  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_PWM <= 2'h0;
    end else begin
      O_PWM <= (pre & out_en_q & ~(flt_en_q & {2{I_FAULT}})) ^ inv_q;
    end
  end

  // ==========================================================================
  // Interrupt and ADC trigger from raw events
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      ris_q      <= 6'h00;
      flt_ris_q  <= 1'b0;
      O_INT      <= 1'b0;
      O_ADC_TRIG <= 1'b0;
    end else begin
      // Set wins over a clear written in the same cycle
      ris_q <= (ris_q & ~((I_WR && I_ADDR == `PWG_OFF_GISC) ? I_WDATA[5:0] : 6'h00)) | ev;
      flt_ris_q <= (flt_ris_q && !(I_WR && I_ADDR == `PWG_OFF_ISC && I_WDATA[`PWG_INTEN_FAULT]))
                   || I_FAULT;
      O_INT      <= |(ris_q & int_sel_q) || (flt_ris_q && flt_int_en_q);
      O_ADC_TRIG <= |(ev & trg_sel_q);
    end
  end

  // ==========================================================================
  // Configuration registers
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      gen_en_q <= 1'b0;
      updown_q <= 1'b0;
      dbg_stop_q <= 1'b0;
      sync_mode_q <= 1'b0;
      out_en_q <= 2'h0;
      inv_q <= 2'h0;
      flt_en_q <= 2'h0;
      flt_int_en_q <= 1'b0;
      int_sel_q <= 6'h00;
      trg_sel_q <= 6'h00;
      gena_q <= 12'h000;
      genb_q <= 12'h000;
      db_en_q <= 1'b0;
      db_rise_q <= `PWG_RST_DB;
      db_fall_q <= `PWG_RST_DB;
    end else if (I_WR) begin
      unique case (I_ADDR)
        `PWG_OFF_GCTL: begin
          gen_en_q    <= I_WDATA[`PWG_GCTL_EN];
          updown_q    <= I_WDATA[`PWG_GCTL_UPDOWN];
          dbg_stop_q  <= I_WDATA[`PWG_GCTL_DBGSTOP];
          sync_mode_q <= I_WDATA[`PWG_GCTL_SYNCUPD];
        end
        `PWG_OFF_ENABLE: out_en_q <= I_WDATA[1:0];
        `PWG_OFF_INVERT: inv_q    <= I_WDATA[1:0];
        `PWG_OFF_FAULT:  flt_en_q <= I_WDATA[1:0];
        `PWG_OFF_INTEN:  flt_int_en_q <= I_WDATA[`PWG_INTEN_FAULT];
        `PWG_OFF_GINTEN: begin
          int_sel_q <= I_WDATA[5:0];
          trg_sel_q <= I_WDATA[`PWG_GINTEN_TRG +: 6];
        end
        `PWG_OFF_GENA:   gena_q    <= I_WDATA[11:0];
        `PWG_OFF_GENB:   genb_q    <= I_WDATA[11:0];
        `PWG_OFF_DBCTL:  db_en_q   <= I_WDATA[0];
        `PWG_OFF_DBRISE: db_rise_q <= I_WDATA[11:0];
        `PWG_OFF_DBFALL: db_fall_q <= I_WDATA[11:0];
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // Read path
  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (I_ADDR)
      `PWG_OFF_CTL:    rd_val[0] = upd_req_q;
      `PWG_OFF_ENABLE: rd_val[1:0] = out_en_q;
      `PWG_OFF_INVERT: rd_val[1:0] = inv_q;
      `PWG_OFF_FAULT:  rd_val[1:0] = flt_en_q;
      `PWG_OFF_INTEN:  rd_val[`PWG_INTEN_FAULT] = flt_int_en_q;
      `PWG_OFF_RIS:    rd_val[`PWG_INTEN_FAULT] = flt_ris_q;
      `PWG_OFF_ISC:    rd_val[`PWG_INTEN_FAULT] = flt_ris_q && flt_int_en_q;
      `PWG_OFF_STATUS: rd_val[1:0] = {dir_q, I_FAULT};
      `PWG_OFF_GCTL:   rd_val[3:0] = {sync_mode_q, dbg_stop_q, updown_q, gen_en_q};
      `PWG_OFF_GINTEN: rd_val[13:0] = {trg_sel_q, 2'h0, int_sel_q};
      `PWG_OFF_GRIS:   rd_val[5:0] = ris_q;
      `PWG_OFF_GISC:   rd_val[5:0] = ris_q & int_sel_q;
      `PWG_OFF_LOAD:   rd_val[15:0] = load_sh_q;
      `PWG_OFF_COUNT:  rd_val[15:0] = cnt_q;
      `PWG_OFF_CMPA:   rd_val[15:0] = cmpa_sh_q;
      `PWG_OFF_CMPB:   rd_val[15:0] = cmpb_sh_q;
      `PWG_OFF_GENA:   rd_val[11:0] = gena_q;
      `PWG_OFF_GENB:   rd_val[11:0] = genb_q;
      `PWG_OFF_DBCTL:  rd_val[0] = db_en_q;
      `PWG_OFF_DBRISE: rd_val[11:0] = db_rise_q;
      `PWG_OFF_DBFALL: rd_val[11:0] = db_fall_q;
      default:         rd_val = 32'h0000_0000;
    endcase
  end

  // Data stand only in the cycle after the read strobe
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_RDATA <= 32'h0000_0000;
    end else begin
      O_RDATA <= I_RD ? rd_val : 32'h0000_0000;
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_ARST_N);

  a_down_reload: assert property ((ev[PWG_EV_ZERO] && !updown_q && !sync_wr) |=> cnt_q == $past(load_eff))
    else $error("down count did not reload at zero");
  a_down_step: assert property ((run && !updown_q && !at_zero && !sync_wr) |=> cnt_q == $past(cnt_q) - 16'h0001)
    else $error("down count did not decrement");
  a_peak_turn: assert property ((run && updown_q && dir_q && at_load && !at_zero && !sync_wr) |=> !dir_q ##1 1'b1)
    else $error("up/down count did not turn at load");
  a_dir_low: assert property ((run && !updown_q && !sync_wr) |=> !dir_q)
    else $error("direction high in down mode");
  a_zero_load: assert property ((ev[PWG_EV_ZERO] && !updown_q && !sync_wr) |=> at_load)
    else $error("zero pulse not followed by load point");
  a_cmp_range: assert property ((cmpa_q > load_q) |-> !ev[PWG_EV_AUP] && !ev[PWG_EV_ADOWN])
    else $error("compare A matched above load");
  a_cmp_discard: assert property ((ev[PWG_EV_ZERO] && mat_a && gena_q[3:0] == 4'h0) |=> gen_a_q == $past(gen_a_q))
    else $error("compare event acted on zero");
  a_force_high: assert property ((evg_a[PWG_EV_ZERO] && !evg_a[PWG_EV_LOAD] && gena_q[1:0] == 2'h3) |=> gen_a_q)
    else $error("force high action not applied");
  a_db_pass: assert property ((!db_en_q && out_en_q[0] && !inv_q[0] && !flt_en_q[0]) |=> O_PWM[0] == $past(gen_a_q))
    else $error("bypass altered first output");
  a_db_overlap: assert property (db_en_q |-> !(db_a && db_b))
    else $error("dead-band outputs overlap");
  a_int_raise: assert property (((|(ev & int_sel_q)) ##1 !I_WR) |=> O_INT)
    else $error("selected event raised no interrupt");
  a_trig_pulse: assert property ((|(ev & trg_sel_q)) |=> O_ADC_TRIG)
    else $error("selected event raised no trigger");
  a_sync_clear: assert property (sync_wr |=> cnt_q == `PWG_RST_CNT)
    else $error("global sync did not clear counter");
  a_hold_value: assert property ((!at_zero) |=> $stable(load_q) && $stable(cmpa_q))
    else $error("value changed away from zero");
  a_sync_wait: assert property ((sync_mode_q && !upd_req_q) |=> $stable(cmpb_q))
    else $error("value changed without update request");
  a_req_clear: assert property ((upd_req_q && at_zero && !req_wr) |=> !upd_req_q)
    else $error("update request did not self-clear");
  a_fault_force: assert property ((I_FAULT && flt_en_q[0]) |=> O_PWM[0] == $past(inv_q[0]))
    else $error("fault did not force output inactive");
  a_idle_pol: assert property ((!out_en_q[1]) |=> O_PWM[1] == $past(inv_q[1]))
    else $error("disabled channel wrong idle level");
  a_stall_halt: assert property ((I_DBG_STALL && dbg_stop_q && at_zero && !sync_wr) |=> $stable(cnt_q))
    else $error("counter moved while halted");

  c_down_zero: cover property (ev[PWG_EV_ZERO] && !updown_q);
  c_updown_turn: cover property (updown_q && dir_q ##1 !dir_q);
  c_db_on: cover property (db_en_q && db_a ##[1:20] db_b);
  c_fault: cover property (I_FAULT && flt_en_q != 2'h0);

endmodule : pwg_top

/* test/pwg_half_bridge_model.sv */
// Half-bridge driver stand-in that counts shoot-through cycles on the pins
module pwg_half_bridge_model (
  input  wire logic        i_clk,
  input  wire logic        i_paired,
  input  wire logic [1:0]  i_gate,
  output logic      [15:0] o_shoot
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Both switches on only hurts when the two pins drive one leg
  always_ff @(posedge i_clk) begin
    if (!i_paired) begin
      o_shoot <= 16'h0000;
    end else if (i_gate == 2'h3) begin
      o_shoot <= o_shoot + 16'h0001;
    end
  end
endmodule : pwg_half_bridge_model

/* test/tb_pwm_generator_deadband.sv */
// Self-checking testbench of the PWM generator
`include "pwg_defines.svh"

module tb_pwm_generator_deadband;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk;
  logic        arst_n;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr_s;
  logic        rd_s;
  logic        fault;
  logic        stall;
  logic [31:0] rdata;
  logic [1:0]  pwm;
  logic        irq;
  logic        trig;
  logic        paired;
  logic [15:0] shoot;
  int          miscompares;
  int          samples_checked;

  pwg_top dut_u (.I_CORE_CLK(clk), .I_ARST_N(arst_n), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr_s),
    .I_RD(rd_s), .I_FAULT(fault), .I_DBG_STALL(stall), .O_RDATA(rdata), .O_PWM(pwm), .O_INT(irq),
    .O_ADC_TRIG(trig));
  pwg_half_bridge_model bridge_u (.i_clk(clk), .i_paired(paired), .i_gate(pwm), .o_shoot(shoot));

  always #2.5 clk = ~clk;

  // ==========================================================================
  // Shared tasks
  task automatic results();
    if (miscompares == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  task automatic tmo(input int k);
    if (k >= 200) begin
      miscompares++;
      $display("FAIL %0t wait expired", $time);
      results();
    end
  endtask : tmo

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr_s  <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr_s  <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    rd_s <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 d = rdata;
  endtask : rd

  task automatic hi(input int n, input int ch, output int k);
    k = 0;
    repeat (n) @(posedge clk) #1 k += int'(pwm[ch]);
  endtask : hi

  // Cycles between two trigger pulses; pulse spacing shows the counter period
  task automatic gap(output int n);
    int k;
    // Look past the edge so a pulse launched there is not missed
    #1;
    for (k = 0; k < 200 && trig !== 1'b1; k++) @(posedge clk) #1;
    tmo(k);
    for (n = 1; n < 200; n++) begin
      @(posedge clk) #1;
      if (trig === 1'b1) break;
    end
    tmo(n);
  endtask : gap

  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    logic [31:0] d;
    chk({pwm, irq, trig}, 4'h0);
    rd(`PWG_OFF_COUNT, d);
    chk(d, 32'h0);
    rd(8'hFC, d);
    chk(d, 32'h0);
  endtask : t_reset

  task automatic t_count();
    int n;
    int r;
    logic p;
    wr(`PWG_OFF_ENABLE, 32'h3);
    wr(`PWG_OFF_LOAD, 32'h3);
    wr(`PWG_OFF_GINTEN, 32'h100);
    wr(`PWG_OFF_GCTL, 32'h1);
    gap(n);
    chk(n, 4);
    wr(`PWG_OFF_GINTEN, 32'h300);
    repeat (8) @(posedge clk);
    #1 p = trig;
    n = 0;
    r = 0;
    // Zero and load pulses adjacent: two pairs in two periods
    repeat (8) begin
      @(posedge clk) #1;
      n += int'(trig);
      r += int'(trig & ~p);
      p = trig;
    end
    chk(n, 4);
    chk(r, 2);
    wr(`PWG_OFF_GCTL, 32'h3);
    wr(`PWG_OFF_GINTEN, 32'h100);
    repeat (12) @(posedge clk);
    gap(n);
    chk(n, 6);
    wr(`PWG_OFF_CMPA, 32'h2);
    wr(`PWG_OFF_GENA, 32'hB0);
    repeat (20) @(posedge clk);
    hi(12, 0, n);
    chk(n, 4);
  endtask : t_count

  task automatic t_gen();
    logic [31:0] ga [4] = '{32'h83, 32'h83, 32'h80, 32'hC83};
    int ca [4] = '{3, 9, 0, 3};
    int cb [4] = '{1, 1, 1, 3};
    int e0 [4] = '{5, 8, 8, 5};
    int e1 [4] = '{6, 6, 6, 4};
    int k;
    wr(`PWG_OFF_GCTL, 32'h1);
    wr(`PWG_OFF_LOAD, 32'h7);
    wr(`PWG_OFF_GENB, 32'h80C);
    for (int i = 0; i < 4; i++) begin
      wr(`PWG_OFF_GENA, ga[i]);
      wr(`PWG_OFF_CMPA, ca[i]);
      wr(`PWG_OFF_CMPB, cb[i]);
      repeat (20) @(posedge clk);
      hi(8, 0, k);
      chk(k, e0[i]);
      hi(8, 1, k);
      chk(k, e1[i]);
    end
  endtask : t_gen

  task automatic t_out();
    int k;
    logic [31:0] d;
    wr(`PWG_OFF_GENA, 32'h83);
    wr(`PWG_OFF_CMPA, 32'h3);
    wr(`PWG_OFF_CMPB, 32'h1);
    wr(`PWG_OFF_INVERT, 32'h2);
    repeat (20) @(posedge clk);
    hi(8, 1, k);
    chk(k, 2);
    wr(`PWG_OFF_ENABLE, 32'h1);
    repeat (4) @(posedge clk);
    hi(8, 1, k);
    chk(k, 8);
    wr(`PWG_OFF_INVERT, 32'h0);
    wr(`PWG_OFF_ENABLE, 32'h3);
    wr(`PWG_OFF_FAULT, 32'h1);
    fault <= 1'b1;
    repeat (4) @(posedge clk);
    hi(8, 0, k);
    chk(k, 0);
    rd(`PWG_OFF_RIS, d);
    chk(d[16], 1'b1);
    @(posedge clk) fault <= 1'b0;
    wr(`PWG_OFF_FAULT, 32'h0);
    wr(`PWG_OFF_ISC, 32'h10000);
    // Held updates must not leak before the request
    wr(`PWG_OFF_GCTL, 32'h9);
    wr(`PWG_OFF_CMPA, 32'h5);
    repeat (20) @(posedge clk);
    hi(8, 0, k);
    chk(k, 5);
    wr(`PWG_OFF_CTL, 32'h1);
    repeat (20) @(posedge clk);
    hi(8, 0, k);
    chk(k, 3);
    rd(`PWG_OFF_CTL, d);
    chk(d, 32'h0);
  endtask : t_out

  task automatic t_db();
    int k;
    wr(`PWG_OFF_GCTL, 32'h1);
    wr(`PWG_OFF_DBRISE, 32'h1);
    wr(`PWG_OFF_DBFALL, 32'h1);
    wr(`PWG_OFF_DBCTL, 32'h1);
    repeat (20) @(posedge clk);
    paired <= 1'b1;
    hi(16, 0, k);
    // Each high phase loses the programmed delay: 3 -> 2 and 5 -> 4 cycles
    chk(k, 4);
    hi(16, 1, k);
    chk(k, 8);
    chk(shoot, 16'h0);
    paired <= 1'b0;
    wr(`PWG_OFF_DBCTL, 32'h0);
  endtask : t_db

  task automatic t_irq();
    int k;
    int n;
    logic [31:0] d;
    wr(`PWG_OFF_GINTEN, 32'h1);
    for (k = 0; k < 200 && irq !== 1'b1; k++) @(posedge clk) #1;
    tmo(k);
    rd(`PWG_OFF_GRIS, d);
    chk(d[0], 1'b1);
    n = 0;
    repeat (16) @(posedge clk) #1 n += int'(trig);
    chk(n, 0);
    wr(`PWG_OFF_GCTL, 32'h0);
    wr(`PWG_OFF_GISC, 32'h3F);
    repeat (3) @(posedge clk);
    #1 chk(irq, 1'b0);
    wr(`PWG_OFF_SYNC, 32'h1);
    rd(`PWG_OFF_COUNT, d);
    chk(d, 32'h0);
    @(posedge clk) stall <= 1'b1;
    wr(`PWG_OFF_GCTL, 32'h5);
    repeat (10) @(posedge clk);
    wr(`PWG_OFF_GISC, 32'h3F);
    repeat (30) @(posedge clk);
    rd(`PWG_OFF_COUNT, d);
    chk(d, 32'h0);
    chk(irq, 1'b0);
    @(posedge clk) stall <= 1'b0;
  endtask : t_irq

  initial begin
    clk = 1'b0;
    arst_n = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    wr_s = 1'b0;
    rd_s = 1'b0;
    fault = 1'b0;
    stall = 1'b0;
    paired = 1'b0;
    miscompares = 0;
    samples_checked = 0;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    #1 t_reset();
    t_count();
    t_gen();
    t_out();
    t_db();
    t_irq();
    results();
  end
endmodule : tb_pwm_generator_deadband
